// [logic/io_unit_setting_exchange.sv]
// Setting, control and monitor word exchange between an I/O unit and the CPU memory
`timescale 1ns/1ps
`include "io_setting_defs.svh"

// Summary of operation
// - Group 3 refreshed continuously if pointer set
// - Group 3 first fetched after startup ends
// - Group 4 loaded once if pointer set
// - Control words flow CPU to unit continuously if expansion and control pointers set
// - Monitor words flow unit to CPU continuously if expansion and control pointers set
// - Range error in groups 1, 2 lights lamp
// - Offset of lowest bad word published
// - Expansion area offsets start at 100
// - Group 1 errors flagged immediately
// - Group 2 errors flagged only at startup
// - Selector 12345 copies defaults to CPU
// - Selector cleared after default copy
// - Cleared selector means load from CPU
// - Factory defaults are read-only constants
// - Per-unit restart bit restarts this unit
// - Other selector value loads group 2 once
// - Group 1 refreshed continuously, every mode
module io_unit_setting_exchange (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic         wb_we_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic              irq,
  output logic              memReq,
  output logic              memWe,
  output logic      [15:0]  memAddr,
  output logic      [15:0]  memWdata,
  input  wire logic [15:0]  memRdata,
  input  wire logic         memAck,
  input  wire logic [95:0]  restartBits,
  input  wire logic [6:0]   unitNumber,
  input  wire logic [63:0]  monWords,
  output logic      [191:0] settingWords,
  output logic      [31:0]  ctlWords,
  output logic              settingErrorLamp
);

  io_setting_pkg::seq_type seq_ff;
  logic [3:0]  idx_ff;
  logic        busy_ff;
  logic [15:0] addr_ff;
  logic [15:0] wdata_ff;
  logic        we_ff;
  logic [15:0] base_ff;
  logic [15:0] extPtr_ff;
  logic [15:0] setWords_ff [0:`SET_WORDS-1];
  logic [15:0] ctl_ff [0:`CTL_WORDS-1];
  logic        errValid_ff;
  logic [15:0] errOfs_ff;
  logic        running_ff;
  logic        defCopied_ff;
  logic        restartPrev_ff;
  logic        softRestart_ff;
  logic [`IRQ_BITS-1:0] irqStat_ff;
  logic [`IRQ_BITS-1:0] irqMask_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;

  logic        restartBit;
  logic        restartReq;
  logic        xferDone;
  logic [3:0]  lastIdx;
  logic [15:0] ctlPtr;
  logic        wordBad;
  logic [15:0] badOfs;
  logic        rangeEvent;
  logic        defDoneEvent;
  logic        startEvent;
  logic        wbReq;
  logic        wbWrite;
  logic [`IRQ_BITS-1:0] irqSet;

  // Factory defaults live in logic constants, so no memory write can alter them
  function automatic logic [15:0] defaultWord(input logic [3:0] i);
    if (i < 4'(`G2_IDX))
      defaultWord = `DEF_G1;
    else if (i < 4'(`G3_IDX))
      defaultWord = `DEF_G2;
    else if (i < 4'(`G4_IDX))
      defaultWord = `DEF_G3;
    else
      defaultWord = `DEF_G4;
  endfunction

  // Data memory word for the current step of the sequence
  function automatic logic [15:0] stepAddr(input io_setting_pkg::seq_type s,
                                           input logic [3:0] i,
                                           input logic [15:0] base,
                                           input logic [15:0] ptr,
                                           input logic [15:0] cptr);
    logic [15:0] wi;
    wi = {12'h000, i};
    unique case (s)
      io_setting_pkg::SEQ_SEL,
      io_setting_pkg::SEQ_CLRSEL: stepAddr = base + `SEL_OFS;
      io_setting_pkg::SEQ_PTR:    stepAddr = base + `EXT_PTR_OFS;
      io_setting_pkg::SEQ_DEF:    stepAddr = (i < 4'(`G3_IDX)) ? base + `G1_OFS + wi
                                             : ptr + wi - 16'h0008;
      io_setting_pkg::SEQ_G1:     stepAddr = base + `G1_OFS + wi;
      io_setting_pkg::SEQ_G2:     stepAddr = base + `G2_OFS + wi;
      io_setting_pkg::SEQ_G3:     stepAddr = ptr + wi;
      io_setting_pkg::SEQ_G4:     stepAddr = ptr + 16'(`G3_WORDS) + wi;
      io_setting_pkg::SEQ_CTL:    stepAddr = cptr + wi;
      io_setting_pkg::SEQ_MON:    stepAddr = cptr + `MON_OFS + wi;
      io_setting_pkg::SEQ_ERR:    stepAddr = base + `ERR_OFS;
    endcase
  endfunction

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    for (int b = 0; b < 4; b++)
      laneMerge[b*8 +: 8] = sel[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  // Restart request: power-on handled by reset, unit restart by its own bit
  assign restartBit = (unitNumber < 7'(`UNIT_COUNT)) ? restartBits[unitNumber] : 1'b0;
  assign restartReq = (restartBit & ~restartPrev_ff) | softRestart_ff;

  assign xferDone = busy_ff & memAck;
  assign ctlPtr   = setWords_ff[`G4_IDX];

  always_comb begin
    unique case (seq_ff)
      io_setting_pkg::SEQ_DEF: lastIdx = (extPtr_ff != 16'h0000) ? 4'(`SET_WORDS - 1)
                                                              : 4'(`G3_IDX - 1);
      io_setting_pkg::SEQ_G1:  lastIdx = 4'(`G1_WORDS - 1);
      io_setting_pkg::SEQ_G2:  lastIdx = 4'(`G2_WORDS - 1);
      io_setting_pkg::SEQ_G3:  lastIdx = 4'(`G3_WORDS - 1);
      io_setting_pkg::SEQ_G4:  lastIdx = 4'(`G4_WORDS - 1);
      io_setting_pkg::SEQ_CTL: lastIdx = 4'(`CTL_WORDS - 1);
      io_setting_pkg::SEQ_MON: lastIdx = 4'(`MON_WORDS - 1);
      default:                 lastIdx = 4'h0;
    endcase
  end

  // Range check on groups 1 and 2 and on the startup-only expansion group
  always_comb begin
    wordBad = 1'b0;
    badOfs  = 16'h0000;
    if (xferDone && memRdata > `SET_WORD_MAX) begin
      if (seq_ff == io_setting_pkg::SEQ_G1) begin
        wordBad = 1'b1;
        badOfs  = `G1_OFS + {12'h000, idx_ff};
      end else if (seq_ff == io_setting_pkg::SEQ_G2) begin
        wordBad = 1'b1;
        badOfs  = `G2_OFS + {12'h000, idx_ff};
      end else if (seq_ff == io_setting_pkg::SEQ_G4) begin
        wordBad = 1'b1;
        badOfs  = `EXT_ERR_BASE + 16'(`G3_WORDS) + {12'h000, idx_ff};
      end
    end
  end
  assign rangeEvent   = wordBad;
  assign defDoneEvent = xferDone & (seq_ff == io_setting_pkg::SEQ_CLRSEL);
  assign startEvent   = xferDone & ~running_ff & (seq_ff == io_setting_pkg::SEQ_G1)
                        & (idx_ff == lastIdx);

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_ff  <= io_setting_pkg::SEQ_SEL;
      idx_ff  <= 4'h0;
      busy_ff <= 1'b0;
      addr_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      we_ff   <= 1'b0;
    end else if (ce) begin
      if (restartReq && !busy_ff) begin
        seq_ff  <= io_setting_pkg::SEQ_SEL;
        idx_ff  <= 4'h0;
        busy_ff <= 1'b1;
        addr_ff <= base_ff + `SEL_OFS;
        we_ff   <= 1'b0;
      end else if (!busy_ff) begin
        busy_ff <= 1'b1;
        addr_ff <= stepAddr(seq_ff, idx_ff, base_ff, extPtr_ff, ctlPtr);
        unique case (seq_ff)
          io_setting_pkg::SEQ_DEF: begin
            we_ff    <= 1'b1;
            wdata_ff <= defaultWord(idx_ff);
          end
          io_setting_pkg::SEQ_CLRSEL: begin
            we_ff    <= 1'b1;
            wdata_ff <= `SEL_CLEARED;
          end
          io_setting_pkg::SEQ_MON: begin
            we_ff    <= 1'b1;
            wdata_ff <= monWords[idx_ff[1:0]*16 +: 16];
          end
          io_setting_pkg::SEQ_ERR: begin
            we_ff    <= 1'b1;
            wdata_ff <= errValid_ff ? errOfs_ff : 16'h0000;
          end
          default: begin
            we_ff    <= 1'b0;
            wdata_ff <= 16'h0000;
          end
        endcase
      end else if (memAck) begin
        busy_ff <= 1'b0;
        if (idx_ff != lastIdx) begin
          idx_ff <= idx_ff + 4'h1;
        end else begin
          idx_ff <= 4'h0;
          unique case (seq_ff)
            io_setting_pkg::SEQ_SEL:    seq_ff <= io_setting_pkg::SEQ_PTR;
            io_setting_pkg::SEQ_PTR:    seq_ff <= defCopied_ff ? io_setting_pkg::SEQ_DEF
                                                  : io_setting_pkg::SEQ_G2;
            io_setting_pkg::SEQ_DEF:    seq_ff <= io_setting_pkg::SEQ_CLRSEL;
            io_setting_pkg::SEQ_CLRSEL: seq_ff <= io_setting_pkg::SEQ_G1;
            io_setting_pkg::SEQ_G2:     seq_ff <= (extPtr_ff != 16'h0000)
                                                  ? io_setting_pkg::SEQ_G4
                                                  : io_setting_pkg::SEQ_G1;
            io_setting_pkg::SEQ_G4:     seq_ff <= io_setting_pkg::SEQ_G1;
            io_setting_pkg::SEQ_G1:     seq_ff <= (extPtr_ff != 16'h0000)
                                                  ? io_setting_pkg::SEQ_G3
                                                  : io_setting_pkg::SEQ_ERR;
            io_setting_pkg::SEQ_G3:     seq_ff <= (ctlPtr != 16'h0000)
                                                  ? io_setting_pkg::SEQ_CTL
                                                  : io_setting_pkg::SEQ_ERR;
            io_setting_pkg::SEQ_CTL:    seq_ff <= io_setting_pkg::SEQ_MON;
            io_setting_pkg::SEQ_MON:    seq_ff <= io_setting_pkg::SEQ_ERR;
            io_setting_pkg::SEQ_ERR:    seq_ff <= io_setting_pkg::SEQ_G1;
          endcase
        end
      end
    end
  end

  // Selector and pointer capture; defCopied flags the default-copy boot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extPtr_ff    <= 16'h0000;
      defCopied_ff <= 1'b0;
      running_ff   <= 1'b0;
    end else if (ce) begin
      if (restartReq && !busy_ff) begin
        running_ff <= 1'b0;
      end else if (xferDone) begin
        if (seq_ff == io_setting_pkg::SEQ_SEL)
          defCopied_ff <= (memRdata == `DEFAULTS_CMD);
        if (seq_ff == io_setting_pkg::SEQ_PTR)
          extPtr_ff <= memRdata;
        if (startEvent)
          running_ff <= 1'b1;
      end
    end
  end

  // Setting words: loaded from CPU memory, or from defaults on a copy boot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `SET_WORDS; i++)
        setWords_ff[i] <= defaultWord(4'(i));
    end else if (ce && xferDone) begin
      unique case (seq_ff)
        io_setting_pkg::SEQ_DEF: setWords_ff[idx_ff] <= defaultWord(idx_ff);
        io_setting_pkg::SEQ_G1:  setWords_ff[idx_ff] <= memRdata;
        io_setting_pkg::SEQ_G2:  setWords_ff[4'(`G2_IDX) + idx_ff] <= memRdata;
        io_setting_pkg::SEQ_G3:  setWords_ff[4'(`G3_IDX) + idx_ff] <= memRdata;
        io_setting_pkg::SEQ_G4:  setWords_ff[4'(`G4_IDX) + idx_ff] <= memRdata;
        default: ;
      endcase
    end
  end

  // Control words from the CPU
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `CTL_WORDS; i++)
        ctl_ff[i] <= 16'h0000;
    end else if (ce && xferDone && seq_ff == io_setting_pkg::SEQ_CTL) begin
      ctl_ff[idx_ff[0]] <= memRdata;
    end
  end

  // Error latch keeps the lowest offending offset until a restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errValid_ff <= 1'b0;
      errOfs_ff   <= 16'h0000;
    end else if (ce) begin
      if (restartReq && !busy_ff) begin
        errValid_ff <= 1'b0;
        errOfs_ff   <= 16'h0000;
      end else if (wordBad && (!errValid_ff || badOfs < errOfs_ff)) begin
        errValid_ff <= 1'b1;
        errOfs_ff   <= badOfs;
      end
    end
  end

  // Restart edge and one-shot software restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restartPrev_ff <= 1'b0;
    end else if (ce) begin
      restartPrev_ff <= restartBit;
    end
  end

  // Wishbone slave: one wait state, ack for every address
  assign wbReq   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wbWrite = wbReq & wb_we_i;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff   <= wbReq;
      rdata_ff <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        unique case (wb_adr_i)
          `REG_BASE:     rdata_ff <= {16'h0000, base_ff};
          `REG_STATUS:   rdata_ff <= {errOfs_ff, 13'h0000, defCopied_ff, running_ff,
                                      errValid_ff};
          `REG_IRQ_STAT: rdata_ff <= {29'h0000_0000, irqStat_ff};
          `REG_IRQ_MASK: rdata_ff <= {29'h0000_0000, irqMask_ff};
          default:       rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_ff        <= `BASE_RESET;
      irqMask_ff     <= '0;
      softRestart_ff <= 1'b0;
    end else if (ce) begin
      softRestart_ff <= restartReq & busy_ff;
      if (wbWrite) begin
        unique case (wb_adr_i)
          `REG_CTRL:
            if (wb_sel_i[0] && wb_dat_i[`CTRL_RESTART])
              softRestart_ff <= 1'b1;
          `REG_BASE:
            base_ff <= 16'(laneMerge({16'h0000, base_ff}, wb_dat_i, wb_sel_i));
          `REG_IRQ_MASK:
            if (wb_sel_i[0])
              irqMask_ff <= wb_dat_i[`IRQ_BITS-1:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky events; a new event in the clearing cycle stays set
  assign irqSet = {startEvent, defDoneEvent, rangeEvent};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_ff <= '0;
    end else if (ce) begin
      if (wbWrite && wb_adr_i == `REG_IRQ_STAT && wb_sel_i[0])
        irqStat_ff <= (irqStat_ff & ~wb_dat_i[`IRQ_BITS-1:0]) | irqSet;
      else
        irqStat_ff <= irqStat_ff | irqSet;
    end
  end

  // Outputs
  genvar g;
  generate
    for (g = 0; g < `SET_WORDS; g++) begin : gSet
      assign settingWords[g*16 +: 16] = setWords_ff[g];
    end
  endgenerate

  assign ctlWords         = {ctl_ff[1], ctl_ff[0]};
  assign settingErrorLamp = errValid_ff;
  assign irq              = |(irqStat_ff & irqMask_ff);
  assign wb_ack_o         = ack_ff;
  assign wb_dat_o         = rdata_ff;
  assign memReq           = busy_ff;
  assign memWe            = we_ff;
  assign memAddr          = addr_ff;
  assign memWdata         = wdata_ff;

endmodule // io_unit_setting_exchange

// [logic/io_setting_defs.svh]
// Offsets, codes, reset values and bus map of the setting exchange block
`ifndef IO_SETTING_DEFS_SVH
`define IO_SETTING_DEFS_SVH

// Shared data memory layout, relative to base word m
`define SEL_OFS        16'h0000
`define G1_OFS         16'h0001
`define G2_OFS         16'h0005
`define ERR_OFS        16'h0009
`define EXT_PTR_OFS    16'h0062
`define G1_WORDS       4
`define G2_WORDS       4
`define G3_WORDS       2
`define G4_WORDS       2
`define CTL_WORDS      2
`define MON_WORDS      4
`define SET_WORDS      12
`define G2_IDX         4
`define G3_IDX         8
`define G4_IDX         10
`define EXT_ERR_BASE   16'h0064
`define MON_OFS        16'h0002
`define DEFAULTS_CMD   16'h3039
`define SEL_CLEARED    16'h0000
`define SET_WORD_MAX   16'h270F

// Read-only factory defaults, one value per setting group
`define DEF_G1         16'h0000
`define DEF_G2         16'h0001
`define DEF_G3         16'h0000
`define DEF_G4         16'h0000
`define BASE_RESET     16'h0000

// Unit restart bits
`define UNIT_COUNT     96

// Wishbone register byte addresses
`define REG_CTRL       8'h00
`define REG_BASE       8'h04
`define REG_STATUS     8'h08
`define REG_IRQ_STAT   8'h0C
`define REG_IRQ_MASK   8'h10

// Field positions
`define CTRL_RESTART   0
`define ST_LAMP        0
`define ST_RUNNING     1
`define ST_DEFCOPIED   2
`define IRQ_RANGE      0
`define IRQ_DEFDONE    1
`define IRQ_STARTED    2
`define IRQ_BITS       3
`endif

// [logic/io_setting_pkg.sv]
// Types of the setting exchange block
package io_setting_pkg;
  typedef enum logic [3:0] {
    SEQ_SEL, SEQ_PTR, SEQ_DEF, SEQ_CLRSEL, SEQ_G2, SEQ_G4,
    SEQ_G1, SEQ_G3, SEQ_CTL, SEQ_MON, SEQ_ERR
  } seq_type;
endpackage

// [test/io_setting_asserts.sv]
// Port-level checks of the setting exchange block
`timescale 1ns/1ps
`include "io_setting_defs.svh"
module io_setting_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  input wire logic        memAck,
  input wire logic [95:0] restartBits,
  input wire logic [6:0]  unitNumber,
  input wire logic        settingErrorLamp
);
  logic       bootSeen_ff;
  logic       bitPrev_ff;
  logic [6:0] sinceRestart_ff;
  logic [6:0] sinceBad_ff;
  logic       restartHit;
  logic       badRead;
  assign restartHit = (restartBits[unitNumber] & ~bitPrev_ff) | (wb_cyc_i & wb_stb_i & wb_we_i
    & ~wb_ack_o & wb_sel_i[0] & wb_dat_i[0] & (wb_adr_i == `REG_CTRL));
  assign badRead = memReq & memAck & ~memWe & (memRdata > `SET_WORD_MAX);
  // Counters saturate so an old cause never looks recent
  always_ff @(posedge clk) begin
    bootSeen_ff     <= ~rst_n;
    bitPrev_ff      <= restartBits[unitNumber];
    sinceRestart_ff <= (restartHit | ~rst_n) ? 7'h00
                       : sinceRestart_ff + {6'h00, ~&sinceRestart_ff};
    sinceBad_ff     <= ~rst_n ? 7'h7F : badRead ? 7'h00 : sinceBad_ff + {6'h00, ~&sinceBad_ff};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence xferDone;
    memReq && memAck && ce;
  endsequence
  sequence regTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (regTaken |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_rdata_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data nonzero without ack");
  a_req_held_steady: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memWe) && $stable(memWdata)) else $error("memory request changed before ack");
  a_req_gap_one: assert property (xferDone ##1 ce |-> !memReq ##1 memReq)
    else $error("gap between memory transfers not one cycle");
  a_boot_reads_sel: assert property (bootSeen_ff |=> memReq && !memWe && memAddr == `SEL_OFS)
    else $error("startup did not begin with selector read");
  a_lamp_has_cause: assert property ($rose(settingErrorLamp) |-> sinceBad_ff < 7'h78)
    else $error("lamp lit without out of range word");
  a_lamp_persists: assert property ($fell(settingErrorLamp) |-> sinceRestart_ff < 7'h20)
    else $error("lamp cleared without restart");
endmodule // io_setting_asserts

// [test/cpu_memory_model.sv]
// Behavioural model of the CPU shared data memory
`timescale 1ns/1ps
module cpu_memory_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata,
  output logic             memAck
);
  logic [15:0] mem [0:1023];
  int          waitCnt;
  initial begin
    memAck = 1'b0;
    memRdata = 16'h0000;
    waitCnt = 0;
    for (int i = 0; i < 1024; i++) mem[i] = 16'h0000;
  end
  // Read data toggles outside the ack cycle so a late sample cannot pass
  always @(posedge clk) begin
    memAck   <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (waitCnt == 0) begin
        memAck  <= 1'b1;
        waitCnt <= slow ? $urandom_range(4, 0) : 0;
        if (memWe) mem[memAddr[9:0]] <= memWdata;
        else memRdata <= mem[memAddr[9:0]];
      end else begin
        waitCnt <= waitCnt - 1;
      end
    end
  end
endmodule // cpu_memory_model

// [test/io_unit_setting_exchange_bench.sv]
// Self-checking bench of the setting exchange block
`timescale 1ns/1ps
`include "io_setting_defs.svh"
module io_unit_setting_exchange_bench;
  localparam logic [15:0] baseM = 16'h0040;
  localparam logic [15:0] ptrP  = 16'h0100;
  localparam logic [15:0] ctlC  = 16'h0200;
  logic         clk, rst_n, ce, wbWe, wbCyc, wbStb, wbAck, irq, lamp, memReq, memWe, memAck, slow;
  logic [7:0]   wbAdr;
  logic [31:0]  wbDatI, wbDatO, rd, ctlWords;
  logic [3:0]   wbSel;
  logic [15:0]  memAddr, memWdata, memRdata, v;
  logic [95:0]  restartBits;
  logic [6:0]   unitNumber;
  logic [63:0]  monWords;
  logic [191:0] settingWords;
  logic [15:0]  g [0:11];
  int           fails, checks;
  io_unit_setting_exchange dut_u (
    .clk(clk), .rst_n(rst_n), .ce(ce), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel),
    .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .irq(irq), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .restartBits(restartBits), .unitNumber(unitNumber),
    .monWords(monWords), .settingWords(settingWords), .ctlWords(ctlWords),
    .settingErrorLamp(lamp));
  cpu_memory_model mem_u (
    .clk(clk), .slow(slow), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    return 16'($urandom_range(`SET_WORD_MAX, 0));
  endfunction
  function automatic int addrOf(input int i);
    return i < 8 ? baseM + 1 + i : ptrP + i - 8;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20) begin
      chk("wbTimeout", 32'h0000_0000, 32'h0000_0001);
      finish_test();
    end
  endtask
  // Counts completed run passes by their error-word write
  task automatic waitLoops(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 4000) begin
      @(posedge clk);
      n++;
      if (memReq && memAck && memWe && memAddr == baseM + `ERR_OFS) k--;
    end
    if (k > 0) begin
      chk("loopTimeout", 32'h0000_0000, 32'h0000_0001);
      finish_test();
    end
  endtask
  task automatic restart(input bit viaBit);
    if (viaBit) begin
      @(posedge clk);
      restartBits[unitNumber] <= 1'b1;
      repeat (3) @(posedge clk);
      restartBits <= '0;
    end else begin
      wb(1'b1, `REG_CTRL, 32'h0000_0001);
    end
    waitLoops(3);
  endtask
  task automatic chkSet();
    for (int i = 0; i < 12; i++) chk("settingWord", {16'h0000, g[i]}, 32'(settingWords[16*i +: 16]));
  endtask
  task automatic chkMon();
    for (int i = 0; i < 4; i++) chk("monitor", 32'(monWords[16*i +: 16]), 32'(mem_u.mem[ctlC+2+i]));
  endtask
  initial begin
    void'($urandom(32'h880F_02CE));
    rst_n = 1'b0;
    ce = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0000_0000;
    wbSel = 4'hF;
    slow = 1'b1;
    restartBits = '0;
    unitNumber = 7'($urandom_range(95, 0));
    monWords = {$urandom, $urandom};
    fails = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `REG_IRQ_MASK, 32'h0000_0000);
    chk("maskReset", 32'h0000_0000, rd);
    wb(1'b1, `REG_BASE, {16'hFFFF, baseM});
    wb(1'b0, `REG_BASE, 32'h0000_0000);
    chk("base", {16'h0000, baseM}, {16'h0000, rd[15:0]});
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    wb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    wb(1'b1, `REG_IRQ_MASK, 32'h0000_0007);
    wb(1'b0, `REG_IRQ_MASK, 32'h0000_0000);
    chk("mask", 32'h0000_0007, {29'h0, rd[2:0]});
    // Load from CPU memory, then change every group without a restart
    @(negedge clk);
    for (int i = 0; i < 12; i++) g[i] = i == 10 ? ctlC : rnd();
    for (int i = 0; i < 12; i++) mem_u.mem[addrOf(i)] = g[i];
    mem_u.mem[baseM + `EXT_PTR_OFS] = ptrP;
    mem_u.mem[ctlC] = rnd();
    mem_u.mem[ctlC + 1] = rnd();
    restart(1'b1);
    chkSet();
    chk("ctl", {mem_u.mem[ctlC + 1], mem_u.mem[ctlC]}, ctlWords);
    chkMon();
    chk("errWord", 32'h0000_0000, 32'(mem_u.mem[baseM + `ERR_OFS]));
    // Clock enable low must freeze the memory address while no request is in flight
    ce <= 1'b0;
    @(posedge clk);
    v = memAddr;
    repeat (8) @(posedge clk);
    chk("ceFreeze", {16'h0000, v}, {16'h0000, memAddr});
    ce <= 1'b1;
    monWords <= {$urandom, $urandom};
    @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      v = i == 10 ? ctlC + 16'h0010 : rnd();
      mem_u.mem[addrOf(i)] = v;
      if (i < 4 || i == 8 || i == 9) g[i] = v;
    end
    waitLoops(3);
    chkSet();
    chkMon();
    // Default copy while CPU memory holds other values
    wb(1'b1, `REG_IRQ_STAT, 32'h0000_0007);
    mem_u.mem[baseM] = `DEFAULTS_CMD;
    restart(1'b0);
    chk("selector", 32'(`SEL_CLEARED), 32'(mem_u.mem[baseM]));
    for (int i = 0; i < 12; i++) begin
      g[i] = i < 4 ? `DEF_G1 : i < 8 ? `DEF_G2 : i < 10 ? `DEF_G3 : `DEF_G4;
      chk("defaultWord", 32'(g[i]), 32'(mem_u.mem[addrOf(i)]));
    end
    chkSet();
    wb(1'b0, `REG_IRQ_STAT, 32'h0000_0000);
    chk("irqStat", 32'h0000_0006, {29'h0, rd[2:0]});
    chk("irqUp", 32'h0000_0001, 32'(irq));
    wb(1'b1, `REG_IRQ_STAT, 32'h0000_0007);
    chk("irqCleared", 32'h0000_0000, 32'(irq));
    wb(1'b1, `REG_IRQ_MASK, 32'h0000_0000);
    restart(1'b0);
    chk("irqMasked", 32'h0000_0000, 32'(irq));
    wb(1'b1, `REG_IRQ_MASK, 32'h0000_0007);
    chk("irqUnmasked", 32'h0000_0001, 32'(irq));
    // Group 1 error at offsets 3 and 4: first one reported at once
    mem_u.mem[baseM + 3] = 16'h2710;
    mem_u.mem[baseM + 4] = 16'hFFFF;
    waitLoops(2);
    chk("lampG1", 32'h0000_0001, 32'(lamp));
    chk("errG1", 32'h0000_0003, 32'(mem_u.mem[baseM + `ERR_OFS]));
    wb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("statusErr", 32'h0003_0001, {rd[31:16], 15'h0, rd[0]});
    mem_u.mem[baseM + 3] = 16'h270F;
    mem_u.mem[baseM + 4] = 16'h0000;
    waitLoops(2);
    chk("lampHeld", 32'h0000_0001, 32'(lamp));
    restart(1'b1);
    chk("lampCleared", 32'h0000_0000, 32'(lamp));
    // Group 2 error shows only after a restart
    mem_u.mem[baseM + 6] = 16'hFFFF;
    waitLoops(3);
    chk("lampG2Quiet", 32'h0000_0000, 32'(lamp));
    restart(1'b0);
    chk("lampG2", 32'h0000_0001, 32'(lamp));
    chk("errG2", 32'h0000_0006, 32'(mem_u.mem[baseM + `ERR_OFS]));
    // Expansion group error reports from offset 100 upward
    mem_u.mem[baseM + 6] = 16'h0000;
    mem_u.mem[ptrP + 3] = 16'hFFFF;
    restart(1'b1);
    chk("errExt", 32'h0000_0067, 32'(mem_u.mem[baseM + `ERR_OFS]));
    finish_test();
  end
endmodule // io_unit_setting_exchange_bench
bind io_unit_setting_exchange io_setting_asserts chk_u (
  .clk, .rst_n, .ce, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .memReq, .memWe, .memAddr, .memWdata, .memRdata, .memAck,
  .restartBits, .unitNumber, .settingErrorLamp);
